/* core/rtc_pkg.sv */
// Purpose: shared constants for the clock configuration and status block
// Assumes: 25 MHz system clock, AXI4-Lite register access
// Notes:   register offsets are byte addresses of aligned 32-bit words
package rtc_pkg;

    localparam int unsigned CLK_PERIOD_NS   = 40;
    localparam int unsigned HALF_PERIOD_NS  = 500000000;
    localparam int unsigned HALF_PERIOD_CYC = HALF_PERIOD_NS / CLK_PERIOD_NS;
    // ripple window ahead of each second rollover
    localparam int unsigned SYNC_LEAD_NS    = 1280;
    localparam int unsigned SYNC_LEAD_CYC   = (SYNC_LEAD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int          CNT_W           = 24;

    localparam int          ADDR_W          = 4;
    localparam logic [3:0]  ADDR_CFG        = 4'h0;
    localparam logic [3:0]  ADDR_VAL        = 4'h4;

    localparam int          BIT_EN          = 15;
    localparam int          BIT_WREN        = 13;
    localparam int          BIT_SYNC        = 12;
    localparam int          BIT_HALF        = 11;
    localparam int          BIT_OE          = 10;
    localparam int          PTR_LO          = 8;
    localparam int          PTR_HI          = 9;

    localparam logic        EN_RESET        = 1'b0;
    localparam logic        WREN_RESET      = 1'b0;
    localparam logic        OE_RESET        = 1'b0;
    localparam logic [7:0]  VAL_RESET       = 8'h00;

    localparam logic [7:0]  SEC_LAST        = 8'h3b;
    localparam logic [7:0]  MIN_LAST        = 8'h3b;
    localparam logic [7:0]  HOUR_LAST       = 8'h17;

    localparam logic [1:0]  RESP_OKAY       = 2'b00;
    localparam logic [1:0]  RESP_SLVERR     = 2'b10;

    typedef enum logic [1:0] {
        PTR_MIN_SEC   = 2'b00,
        PTR_WDAY_HOUR = 2'b01,
        PTR_MONTH_DAY = 2'b10,
        PTR_RESERVED  = 2'b11
    } window_ptr_e;

endpackage

/* core/reg_bus_if.sv */
// Purpose: internal register access strobes between bus slave and register file
// Assumes: single clock, strobes last one cycle
// Notes:   rdata and error answers are combinational from the register side
`timescale 1ns/10ps
`default_nettype none
interface reg_bus_if;
    logic        wr_en;
    logic [3:0]  wr_addr;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        wr_err;
    logic        rd_en;
    logic [3:0]  rd_addr;
    logic [31:0] rdata;
    logic        rd_err;

    modport req (output wr_en, wr_addr, wdata, wstrb, rd_en, rd_addr,
                 input  wr_err, rdata, rd_err);
    modport regs (input  wr_en, wr_addr, wdata, wstrb, rd_en, rd_addr,
                  output wr_err, rdata, rd_err);
endinterface
`default_nettype wire

/* core/rtc_axil_slave.sv */
// Purpose: AXI4-Lite slave turning bus transfers into register strobes
// Assumes: one write and one read outstanding at most
// Notes:   rvalid follows one cycle after the read handshake, bvalid two cycles after the last write handshake
`timescale 1ns/10ps
`default_nettype none
module rtc_axil_slave (
    input  wire logic              aclk,
    input  wire logic              aresetn,
    input  wire logic [3:0]        awaddr,
    input  wire logic              awvalid,
    output logic                   awready,
    input  wire logic [31:0]       wdata,
    input  wire logic [3:0]        wstrb,
    input  wire logic              wvalid,
    output logic                   wready,
    output logic [1:0]             bresp,
    output logic                   bvalid,
    input  wire logic              bready,
    input  wire logic [3:0]        araddr,
    input  wire logic              arvalid,
    output logic                   arready,
    output logic [31:0]            rdata,
    output logic [1:0]             rresp,
    output logic                   rvalid,
    input  wire logic              rready,
    reg_bus_if.req                 bus
);
    logic        aw_held_q, aw_held_d, w_held_q, w_held_d;
    logic [3:0]  addr_q, addr_d, strb_q, strb_d;
    logic [31:0] wdat_q, wdat_d, rdata_d;
    logic        bvalid_d, rvalid_d, awready_d, wready_d, arready_d;
    logic [1:0]  bresp_d, rresp_d;
    logic        do_wr, ar_take;

    always_comb begin
        aw_held_d = aw_held_q | (awvalid & awready);
        w_held_d  = w_held_q | (wvalid & wready);
        addr_d    = (awvalid & awready) ? awaddr : addr_q;
        wdat_d    = (wvalid & wready) ? wdata : wdat_q;
        strb_d    = (wvalid & wready) ? wstrb : strb_q;
        do_wr     = aw_held_q & w_held_q & ~bvalid;
        bvalid_d  = bvalid & ~bready;
        bresp_d   = bresp;
        if (do_wr) begin
            aw_held_d = 1'b0;
            w_held_d  = 1'b0;
            bvalid_d  = 1'b1;
            bresp_d   = bus.wr_err ? rtc_pkg::RESP_SLVERR : rtc_pkg::RESP_OKAY;
        end
        // ready stays low while a response waits, so a second write cannot overtake
        awready_d = ~aw_held_d & ~bvalid_d;
        wready_d  = ~w_held_d & ~bvalid_d;
        ar_take   = arvalid & arready;
        rvalid_d  = rvalid & ~rready;
        rdata_d   = rdata;
        rresp_d   = rresp;
        if (ar_take) begin
            rvalid_d = 1'b1;
            rdata_d  = bus.rdata;
            rresp_d  = bus.rd_err ? rtc_pkg::RESP_SLVERR : rtc_pkg::RESP_OKAY;
        end
        arready_d = ~rvalid_d;
        bus.wr_en   = do_wr;
        bus.wr_addr = addr_q;
        bus.wdata   = wdat_q;
        bus.wstrb   = strb_q;
        bus.rd_en   = ar_take;
        bus.rd_addr = araddr;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_q <= 1'b0;
            w_held_q  <= 1'b0;
            addr_q    <= 4'h0;
            wdat_q    <= 32'h0000_0000;
            strb_q    <= 4'h0;
            awready   <= 1'b0;
            wready    <= 1'b0;
            bvalid    <= 1'b0;
            bresp     <= rtc_pkg::RESP_OKAY;
            arready   <= 1'b0;
            rvalid    <= 1'b0;
            rdata     <= 32'h0000_0000;
            rresp     <= rtc_pkg::RESP_OKAY;
        end else begin
            aw_held_q <= aw_held_d;
            w_held_q  <= w_held_d;
            addr_q    <= addr_d;
            wdat_q    <= wdat_d;
            strb_q    <= strb_d;
            awready   <= awready_d;
            wready    <= wready_d;
            bvalid    <= bvalid_d;
            bresp     <= bresp_d;
            arready   <= arready_d;
            rvalid    <= rvalid_d;
            rdata     <= rdata_d;
            rresp     <= rresp_d;
        end
    end
endmodule
`default_nettype wire

/* core/rtc_timebase.sv */
// Purpose: half-second divider, second tick and ripple warning window
// Assumes: run is the module enable, clear restarts the current second
// Notes:   HALF_CYCLES is shortened in simulation
`timescale 1ns/10ps
`default_nettype none
module rtc_timebase #(
    parameter int unsigned HALF_CYCLES = rtc_pkg::HALF_PERIOD_CYC,
    parameter int unsigned LEAD_CYCLES = rtc_pkg::SYNC_LEAD_CYC
) (
    input  wire logic aclk,
    input  wire logic aresetn,
    input  wire logic run,
    input  wire logic clear,
    output logic      half_flag,
    output logic      sync_flag,
    output logic      sec_tick
);
    localparam logic [rtc_pkg::CNT_W-1:0] CNT_LAST = rtc_pkg::CNT_W'(HALF_CYCLES - 1);
    localparam logic [rtc_pkg::CNT_W-1:0] SYNC_AT  = rtc_pkg::CNT_W'(HALF_CYCLES - LEAD_CYCLES);

    logic [rtc_pkg::CNT_W-1:0] cnt_q, cnt_d;
    logic                      half_d, sync_d, tick_d;

    always_comb begin
        cnt_d  = cnt_q;
        half_d = half_flag;
        tick_d = 1'b0;
        if (clear) begin
            cnt_d  = '0;
            half_d = 1'b0; // R8
        end else if (run) begin
            if (cnt_q == CNT_LAST) begin
                cnt_d  = '0;
                half_d = ~half_flag; // R2
                tick_d = half_flag;
            end else begin
                cnt_d = cnt_q + 1'b1;
            end
        end
        // warn only in the last stretch before the second rolls over
        sync_d = run & ~clear & half_d & (cnt_d >= SYNC_AT); // R1
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt_q     <= '0;
            half_flag <= 1'b0;
            sync_flag <= 1'b0;
            sec_tick  <= 1'b0;
        end else begin
            cnt_q     <= cnt_d;
            half_flag <= half_d;
            sync_flag <= sync_d;
            sec_tick  <= tick_d;
        end
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    property p_sync_before_tick;
        sec_tick |-> $past(sync_flag);
    endproperty
    a_sync_before_tick: assert property (p_sync_before_tick) // R1
        else $error("second rollover without a prior sync warning");

    property p_half_steps;
        $changed(half_flag) && !$past(clear) |-> $past(cnt_q) == CNT_LAST;
    endproperty
    a_half_steps: assert property (p_half_steps) // R2
        else $error("half second flag changed away from a period boundary");

    property p_clear_half;
        clear |=> !half_flag && cnt_q == '0;
    endproperty
    a_clear_half: assert property (p_clear_half) // R8
        else $error("half second flag not cleared");
endmodule
`default_nettype wire

/* core/rtc_config_status_pointer.sv */
// Purpose: configuration, status and value window pointer of a real-time clock
// Assumes: aresetn is the power-on reset, AXI4-Lite at 0x0 config, 0x4 value window
// Notes:   weekday, day and month hold what software wrote; they do not advance
// Summary of operation
// R1 - the sync flag is high while the value windows may change through a rollover ripple.
// R2 - the half second flag is read-only and high in the second half of each second.
// R3 - the clock output pin is driven only while the output enable bit is set.
// R4 - the two-bit window pointer selects which value pair the windows show.
// R5 - high byte codes 00 minutes, 01 weekday, 10 month, 11 reserved; low byte 00 seconds.
// R6 - each access to the value window steps the pointer down by one, stopping at zero; an access in the same cycle as a config write does not step it.
// R7 - a write to the module enable bit takes effect only while value write enable is set.
// R8 - writing the low byte of the minutes-seconds pair clears the half second flag.
// R9 - the configuration register is reset only by power-on reset.
`timescale 1ns/10ps
`default_nettype none
module rtc_config_status_pointer #(
    parameter int unsigned HALF_CYCLES = rtc_pkg::HALF_PERIOD_CYC
) (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [3:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [3:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output logic             clock_out,
    output logic             clock_out_oe
);
    reg_bus_if bus ();

    logic        timekeeping_module_enable_q, timekeeping_module_enable_d;
    logic        value_write_enable_q, value_write_enable_d;
    logic        clock_output_enable_q, clock_output_enable_d;
    logic [1:0]  value_window_pointer_q, value_window_pointer_d;
    logic [7:0]  sec_q, sec_d, min_q, min_d, hour_q, hour_d;
    logic [7:0]  wday_q, wday_d, day_q, day_d, month_q, month_d;
    logic        clock_out_d, clock_out_oe_d;
    logic        half_second_flag, value_read_sync_flag, sec_tick;
    logic        cfg_wr, val_wr, val_rd, minutes_seconds_reg_low_wr;
    logic [7:0]  value_window_high, value_window_low;
    logic        min_wrap, sec_wrap;

    function automatic logic [7:0] step_wrap(input logic [7:0] v, input logic [7:0] last);
        step_wrap = (v == last) ? 8'h00 : v + 8'h01;
    endfunction

    function automatic logic [7:0] byte_merge(input logic [7:0] old, input logic [7:0] nw,
                                              input logic strobe);
        byte_merge = strobe ? nw : old;
    endfunction

    rtc_axil_slave u_slave (
        .aclk    (aclk),
        .aresetn (aresetn),
        .awaddr  (s_axi_awaddr),
        .awvalid (s_axi_awvalid),
        .awready (s_axi_awready),
        .wdata   (s_axi_wdata),
        .wstrb   (s_axi_wstrb),
        .wvalid  (s_axi_wvalid),
        .wready  (s_axi_wready),
        .bresp   (s_axi_bresp),
        .bvalid  (s_axi_bvalid),
        .bready  (s_axi_bready),
        .araddr  (s_axi_araddr),
        .arvalid (s_axi_arvalid),
        .arready (s_axi_arready),
        .rdata   (s_axi_rdata),
        .rresp   (s_axi_rresp),
        .rvalid  (s_axi_rvalid),
        .rready  (s_axi_rready),
        .bus     (bus)
    );

    rtc_timebase #(
        .HALF_CYCLES (HALF_CYCLES),
        .LEAD_CYCLES (rtc_pkg::SYNC_LEAD_CYC)
    ) u_timebase (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .run       (timekeeping_module_enable_q),
        .clear     (minutes_seconds_reg_low_wr),
        .half_flag (half_second_flag),
        .sync_flag (value_read_sync_flag),
        .sec_tick  (sec_tick)
    );

    // value window mux
    always_comb begin
        value_window_high = 8'h00;
        value_window_low  = 8'h00;
        unique case (rtc_pkg::window_ptr_e'(value_window_pointer_q)) // R4
            rtc_pkg::PTR_MIN_SEC: begin
                value_window_high = min_q; // R5
                value_window_low  = sec_q; // R5
            end
            rtc_pkg::PTR_WDAY_HOUR: begin
                value_window_high = wday_q; // R5
                value_window_low  = hour_q;
            end
            rtc_pkg::PTR_MONTH_DAY: begin
                value_window_high = month_q; // R5
                value_window_low  = day_q;
            end
            rtc_pkg::PTR_RESERVED: begin
                value_window_high = 8'h00;
                value_window_low  = 8'h00;
            end
        endcase
    end

    always_comb begin
        cfg_wr = bus.wr_en && bus.wr_addr == rtc_pkg::ADDR_CFG;
        val_wr = bus.wr_en && bus.wr_addr == rtc_pkg::ADDR_VAL;
        val_rd = bus.rd_en && bus.rd_addr == rtc_pkg::ADDR_VAL;
        // locked windows ignore writes, so only an accepted write restarts the second
        minutes_seconds_reg_low_wr = val_wr && value_write_enable_q && bus.wstrb[0]
                        && value_window_pointer_q == rtc_pkg::PTR_MIN_SEC; // R8
        bus.wr_err  = bus.wr_addr != rtc_pkg::ADDR_CFG && bus.wr_addr != rtc_pkg::ADDR_VAL;
        bus.rd_err  = bus.rd_addr != rtc_pkg::ADDR_CFG && bus.rd_addr != rtc_pkg::ADDR_VAL;
        bus.rdata   = 32'h0000_0000;
        if (bus.rd_addr == rtc_pkg::ADDR_CFG) begin
            bus.rdata[rtc_pkg::BIT_EN]   = timekeeping_module_enable_q;
            bus.rdata[rtc_pkg::BIT_WREN] = value_write_enable_q;
            bus.rdata[rtc_pkg::BIT_SYNC] = value_read_sync_flag; // R1
            bus.rdata[rtc_pkg::BIT_HALF] = half_second_flag; // R2
            bus.rdata[rtc_pkg::BIT_OE]   = clock_output_enable_q;
            bus.rdata[rtc_pkg::PTR_HI:rtc_pkg::PTR_LO] = value_window_pointer_q;
        end else if (bus.rd_addr == rtc_pkg::ADDR_VAL) begin
            bus.rdata[15:0] = {value_window_high, value_window_low};
        end
    end

    always_comb begin
        timekeeping_module_enable_d = timekeeping_module_enable_q;
        value_write_enable_d        = value_write_enable_q;
        clock_output_enable_d       = clock_output_enable_q;
        value_window_pointer_d      = value_window_pointer_q;
        sec_wrap = sec_q == rtc_pkg::SEC_LAST;
        min_wrap = min_q == rtc_pkg::MIN_LAST;
        sec_d   = sec_tick ? step_wrap(sec_q, rtc_pkg::SEC_LAST) : sec_q;
        min_d   = (sec_tick && sec_wrap) ? step_wrap(min_q, rtc_pkg::MIN_LAST) : min_q;
        hour_d  = (sec_tick && sec_wrap && min_wrap) ? step_wrap(hour_q, rtc_pkg::HOUR_LAST)
                                                     : hour_q;
        wday_d  = wday_q;
        day_d   = day_q;
        month_d = month_q;
        if (cfg_wr) begin
            if (bus.wstrb[1]) begin
                if (value_write_enable_q) begin
                    timekeeping_module_enable_d = bus.wdata[rtc_pkg::BIT_EN]; // R7
                end
                value_write_enable_d   = bus.wdata[rtc_pkg::BIT_WREN];
                clock_output_enable_d  = bus.wdata[rtc_pkg::BIT_OE];
                value_window_pointer_d = bus.wdata[rtc_pkg::PTR_HI:rtc_pkg::PTR_LO];
            end
        end else if ((val_wr || val_rd) && value_window_pointer_q != 2'b00) begin
            value_window_pointer_d = value_window_pointer_q - 2'b01; // R6
        end
        // software write wins over a tick landing in the same cycle
        if (val_wr && value_write_enable_q) begin
            unique case (rtc_pkg::window_ptr_e'(value_window_pointer_q)) // R4
                rtc_pkg::PTR_MIN_SEC: begin
                    min_d = byte_merge(min_d, bus.wdata[15:8], bus.wstrb[1]);
                    sec_d = byte_merge(sec_d, bus.wdata[7:0], bus.wstrb[0]);
                end
                rtc_pkg::PTR_WDAY_HOUR: begin
                    wday_d = byte_merge(wday_q, bus.wdata[15:8], bus.wstrb[1]);
                    hour_d = byte_merge(hour_d, bus.wdata[7:0], bus.wstrb[0]);
                end
                rtc_pkg::PTR_MONTH_DAY: begin
                    month_d = byte_merge(month_q, bus.wdata[15:8], bus.wstrb[1]);
                    day_d   = byte_merge(day_q, bus.wdata[7:0], bus.wstrb[0]);
                end
                rtc_pkg::PTR_RESERVED: begin
                    month_d = month_q;
                end
            endcase
        end
        clock_out_oe_d = clock_output_enable_q; // R3
        clock_out_d    = clock_output_enable_q & timekeeping_module_enable_q
                         & half_second_flag; // R3
    end

    // only the power-on reset reaches these flops; no other reset source exists here
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            timekeeping_module_enable_q <= rtc_pkg::EN_RESET; // R9
            value_write_enable_q        <= rtc_pkg::WREN_RESET;
            clock_output_enable_q       <= rtc_pkg::OE_RESET;
            value_window_pointer_q      <= rtc_pkg::PTR_MIN_SEC;
            sec_q        <= rtc_pkg::VAL_RESET;
            min_q        <= rtc_pkg::VAL_RESET;
            hour_q       <= rtc_pkg::VAL_RESET;
            wday_q       <= rtc_pkg::VAL_RESET;
            day_q        <= rtc_pkg::VAL_RESET;
            month_q      <= rtc_pkg::VAL_RESET;
            clock_out    <= 1'b0;
            clock_out_oe <= 1'b0;
        end else begin
            timekeeping_module_enable_q <= timekeeping_module_enable_d;
            value_write_enable_q        <= value_write_enable_d;
            clock_output_enable_q       <= clock_output_enable_d;
            value_window_pointer_q      <= value_window_pointer_d;
            sec_q        <= sec_d;
            min_q        <= min_d;
            hour_q       <= hour_d;
            wday_q       <= wday_d;
            day_q        <= day_d;
            month_q      <= month_d;
            clock_out    <= clock_out_d;
            clock_out_oe <= clock_out_oe_d;
        end
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_window_access;
        (val_wr || val_rd) && !cfg_wr;
    endsequence

    property p_ptr_step;
        s_window_access ##0 value_window_pointer_q != 2'b00
            |=> value_window_pointer_q == $past(value_window_pointer_q) - 2'b01;
    endproperty
    a_ptr_step: assert property (p_ptr_step) // R6
        else $error("window pointer did not step down after access");

    property p_ptr_floor;
        s_window_access ##0 value_window_pointer_q == 2'b00 |=> value_window_pointer_q == 2'b00;
    endproperty
    a_ptr_floor: assert property (p_ptr_floor) // R6
        else $error("window pointer moved below zero");

    property p_oe_off;
        !clock_output_enable_q |=> !clock_out_oe && !clock_out;
    endproperty
    a_oe_off: assert property (p_oe_off) // R3
        else $error("clock output driven while disabled");

    property p_out_follows;
        clock_output_enable_q && timekeeping_module_enable_q
            |=> clock_out_oe && clock_out == $past(half_second_flag);
    endproperty
    a_out_follows: assert property (p_out_follows) // R3
        else $error("clock output does not follow the half second flag");

    property p_en_locked;
        cfg_wr && !value_write_enable_q
            |=> timekeeping_module_enable_q == $past(timekeeping_module_enable_q);
    endproperty
    a_en_locked: assert property (p_en_locked) // R7
        else $error("enable changed while value writes locked");

    property p_high_map;
        bus.rd_en && bus.rd_addr == rtc_pkg::ADDR_VAL && value_window_pointer_q == 2'b01
            |-> bus.rdata[15:8] == wday_q;
    endproperty
    a_high_map: assert property (p_high_map) // R5
        else $error("pointer 01 does not map weekday into the high byte");

    property p_low_map;
        bus.rd_en && bus.rd_addr == rtc_pkg::ADDR_VAL && value_window_pointer_q == 2'b00
            |-> bus.rdata[15:0] == {min_q, sec_q};
    endproperty
    a_low_map: assert property (p_low_map) // R4
        else $error("pointer 00 does not map minutes and seconds");

    property p_minutes_seconds_reg_clear;
        minutes_seconds_reg_low_wr |=> !half_second_flag ##1 !value_read_sync_flag;
    endproperty
    a_minutes_seconds_reg_clear: assert property (p_minutes_seconds_reg_clear) // R8
        else $error("half second flag survived a seconds write");
endmodule
`default_nettype wire

/* bench/test_rtc_config_status_pointer.sv */
// Purpose: self-checking bench for the clock configuration and status block
// Assumes: HALF_CYCLES 64, sync window in the last 32 cycles of each second
// Notes:   window tests run with the module disabled so values cannot advance
`timescale 1ns/10ps
`default_nettype none
module test_rtc_config_status_pointer;
    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic [3:0]  awaddr = 4'h0, araddr = 4'h0;
    logic [31:0] wdata = 32'h0, d;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid, clock_out, clock_out_oe;
    logic [1:0]  bresp, rresp;
    logic [31:0] rdata;
    int          err_total = 0, n_compared = 0;
    always #20 aclk = ~aclk;
    rtc_config_status_pointer #(.HALF_CYCLES(64)) DUT (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .clock_out(clock_out), .clock_out_oe(clock_out_oe));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] v);
        awaddr <= a; wdata <= v; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        bready <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a);
        araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        d = rdata; rready <= 1'b0;
        @(posedge aclk);
    endtask
    task automatic t_reset();
        rd(4'h0); chk(d & 32'hffff_e7ff, 32'h0);
        chk(clock_out_oe, 1'b0);
        rd(4'h8); chk(d, 32'h0); chk(rresp, 2'b10);
        wr(4'h8, 32'h0); chk(bresp, 2'b10);
    endtask
    task automatic t_window();
        wr(4'h0, 32'h2200);
        wr(4'h4, 32'h0c05); wr(4'h4, 32'h0302); wr(4'h4, 32'h0a00);
        rd(4'h0); chk(d[9:8], 2'b00);
        wr(4'h0, 32'h2300);
        rd(4'h4); chk(d[15:0], 16'h0000);
        rd(4'h4); chk(d[15:0], 16'h0c05);
        rd(4'h4); chk(d[15:0], 16'h0302);
        rd(4'h4); chk(d[15:0], 16'h0a00);
        rd(4'h0); chk(d[9:8], 2'b00);
    endtask
    task automatic t_status();
        // lock value writes first so the enable write is really refused
        wr(4'h0, 32'h0000);
        wr(4'h0, 32'h8000);
        rd(4'h0); chk(d[15], 1'b0);
        wr(4'h0, 32'h2400);
        wr(4'h0, 32'ha400);
        rd(4'h0); chk(d[15], 1'b1);
        chk(clock_out_oe, 1'b1);
        wr(4'h4, 32'h0a00);
        rd(4'h0); chk(d[12:11], 2'b00);
        repeat (70) @(posedge aclk);
        rd(4'h0); chk(d[12:11], 2'b01);
        chk(clock_out, 1'b1);
        repeat (25) @(posedge aclk);
        rd(4'h0); chk(d[12:11], 2'b11);
        wr(4'h0, 32'ha000);
        // pin flops update one edge after the config bit
        @(posedge aclk);
        chk({clock_out_oe, clock_out}, 2'b00);
    endtask
    task automatic print_verdict();
        $display("compared %0d, mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    initial begin
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_reset();
        t_window();
        t_status();
        print_verdict();
    end
    // whole run is well under a thousand cycles
    initial begin
        #200000;
        err_total++;
        print_verdict();
    end
endmodule
`default_nettype wire
